// ### rtl/hsc_config_regs.sv
/*
  Configuration register bank of a two-port hub, loaded over the two-wire
  serial management bus before the hub attaches upstream. Holds the
  serial byte slave, the command register and the setup bytes.
  Assumes slaveAddress is a static strap and the bus data pin is open-drain
  with a pull-up outside; the serial clock is never stretched here.
*/
//
// Contract
// - Soft reset bit restores slave and storage defaults.
// - Soft reset bit clears itself during reset.
// - Lock bit blocks writes to 01h through 10h.
// - Lock and attach set once, pin reset clears.
// - Attach bit signals upstream attach; zero keeps slave.
// - Slave powers down after attach write acknowledged.
// - Vendor code bytes at 01h and 02h.
// - Product code bytes at 03h and 04h.
// - Release code bytes at 05h and 06h.
// - Setup bit 7 selects bus or self power.
// - Dynamic switching uses sense pin, ignores bit 7.
// - Second setup byte bit 7 enables dynamic switching.
// - Setup bit 5 forces full-speed-only attach.
// - Setup bit 3 suppresses full-speed end-of-packet.
// - Setup bits 2:1 select over-current sensing mode.
`timescale 1ns/1ps

module hsc_config_regs
  import hsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [6:0] slaveAddress,
  input wire logic smbClockPin,
  input wire logic smbDataIn,
  output logic smbDataOut,
  output logic smbDataOe,
  input wire logic localPowerSensePin,
  output logic usbAttach,
  output logic smbInterfaceOff,
  output logic configLock,
  output logic selfPowered,
  output logic dynamicPowerEnable,
  output logic highSpeedOff,
  output logic endOfPacketSuppress,
  output logic [1:0] overcurrentSenseMode,
  output logic [15:0] vendorCode,
  output logic [15:0] productCode,
  output logic [15:0] releaseCode
);

  hsc_state_t st;
  hsc_state_t next_st;
  logic [2:0] pinLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic addressMatch;
  logic [7:0] readByte;
  logic inLockRange;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  hsc_pin_filter u_pin_filter (
    .clock(clock),
    .reset(reset),
    .pinRaw({localPowerSensePin, smbDataIn, smbClockPin}),
    .pinLevel(pinLevel)
  );

  // ----------------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------------
  // Reserved and unmapped bits read as zero; the soft reset bit never
  // reads back as one because the read view never maps it into the command byte.
  function automatic logic [7:0] read_view(input logic [7:0] addr, input hsc_state_t s);
    logic [7:0] value;
    value = 8'h00;
    unique case (addr)
      REG_HUB_COMMAND: begin
        value[CMD_CONFIG_LOCK_BIT] = s.configLock;
        value[CMD_USB_ATTACH_BIT] = s.usbAttach;
      end
      REG_VENDOR_CODE_LOW: value = s.setup.vendorCode[7:0];
      REG_VENDOR_CODE_HIGH: value = s.setup.vendorCode[15:8];
      REG_PRODUCT_CODE_LOW: value = s.setup.productCode[7:0];
      REG_PRODUCT_CODE_HIGH: value = s.setup.productCode[15:8];
      REG_RELEASE_CODE_LOW: value = s.setup.releaseCode[7:0];
      REG_RELEASE_CODE_HIGH: value = s.setup.releaseCode[15:8];
      REG_HUB_SETUP_FIRST: value = s.setup.setupFirst;
      REG_HUB_SETUP_SECOND: value = s.setup.setupSecond;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    sclRise = pinLevel[PIN_SCL] & ~st.sclLast;
    sclFall = ~pinLevel[PIN_SCL] & st.sclLast;
    startSeen = st.sclLast & pinLevel[PIN_SCL] & st.sdaLast & ~pinLevel[PIN_SDA];
    stopSeen = st.sclLast & pinLevel[PIN_SCL] & ~st.sdaLast & pinLevel[PIN_SDA];
    addressMatch = (st.shiftReg[7:1] == slaveAddress) &&
                   (st.shiftReg[7:1] != GENERAL_CALL_ADDRESS);
    readByte = read_view(st.regAddr, st);
    inLockRange = (st.regAddr >= LOCK_RANGE_FIRST) && (st.regAddr <= LOCK_RANGE_LAST);
    next_st.sclLast = pinLevel[PIN_SCL];
    next_st.sdaLast = pinLevel[PIN_SDA];

    if (st.softReset) begin
      // Storage and the slave return to defaults; the one-shot bits survive
      // because only the reset pin may clear them.
      next_st = HSC_STATE_RESET;
      next_st.softReset = 1'b0;
      next_st.configLock = st.configLock;
      next_st.usbAttach = st.usbAttach;
      next_st.sclLast = pinLevel[PIN_SCL];
      next_st.sdaLast = pinLevel[PIN_SDA];
    end else if (st.usbAttach) begin
      // Once attached the slave is dead to the bus until the reset pin.
      next_st.busState = BUS_IDLE;
      next_st.sdaOe = 1'b0;
      next_st.writePending = 1'b0;
    end else if (stopSeen) begin
      // Writes land only at a stop that closes a complete write byte frame,
      // so an aborted or malformed transfer never touches storage.
      if (st.writePending) begin
        if (st.regAddr == REG_HUB_COMMAND) begin
          next_st.configLock = st.configLock | st.dataByte[CMD_CONFIG_LOCK_BIT];
          next_st.usbAttach = st.usbAttach | st.dataByte[CMD_USB_ATTACH_BIT];
          next_st.softReset = st.dataByte[CMD_SOFT_RESET_BIT];
        end else if (!(st.configLock && inLockRange)) begin
          unique case (st.regAddr)
            REG_VENDOR_CODE_LOW: next_st.setup.vendorCode[7:0] = st.dataByte;
            REG_VENDOR_CODE_HIGH: next_st.setup.vendorCode[15:8] = st.dataByte;
            REG_PRODUCT_CODE_LOW: next_st.setup.productCode[7:0] = st.dataByte;
            REG_PRODUCT_CODE_HIGH: next_st.setup.productCode[15:8] = st.dataByte;
            REG_RELEASE_CODE_LOW: next_st.setup.releaseCode[7:0] = st.dataByte;
            REG_RELEASE_CODE_HIGH: next_st.setup.releaseCode[15:8] = st.dataByte;
            REG_HUB_SETUP_FIRST: next_st.setup.setupFirst = st.dataByte & SETUP_FIRST_MASK;
            REG_HUB_SETUP_SECOND: next_st.setup.setupSecond = st.dataByte & SECOND_MASK;
            default: next_st.setup = st.setup;
          endcase
        end
      end
      next_st.busState = BUS_IDLE;
      next_st.phase = PHASE_WRITE_ADDR;
      next_st.writePending = 1'b0;
      next_st.sdaOe = 1'b0;
    end else if (startSeen) begin
      // A repeated start straight after the register byte opens a read.
      // The restart's own clock rise has already shifted in one bit.
      next_st.busState = BUS_RECEIVE;
      next_st.phase = (st.busState == BUS_RECEIVE && st.phase == PHASE_DATA &&
                       st.bitCount <= 4'h1) ? PHASE_READ_ADDR : PHASE_WRITE_ADDR;
      next_st.bitCount = 4'h0;
      next_st.writePending = 1'b0;
      next_st.sdaOe = 1'b0;
    end else begin
      unique case (st.busState)
        BUS_IDLE: begin
          next_st.sdaOe = 1'b0;
        end
        BUS_RECEIVE: begin
          if (sclRise && st.bitCount != BYTE_BITS) begin
            next_st.shiftReg = {st.shiftReg[6:0], pinLevel[PIN_SDA]};
            next_st.bitCount = st.bitCount + 4'h1;
          end else if (sclFall && st.bitCount == BYTE_BITS) begin
            next_st.busState = BUS_ACK;
            next_st.sdaOe = 1'b1;
            unique case (st.phase)
              PHASE_WRITE_ADDR: begin
                if (!addressMatch || st.shiftReg[0]) begin
                  next_st.busState = BUS_IDLE;
                  next_st.sdaOe = 1'b0;
                end
              end
              PHASE_REG_ADDR: next_st.regAddr = st.shiftReg;
              PHASE_DATA: next_st.dataByte = st.shiftReg;
              PHASE_READ_ADDR: begin
                if (!addressMatch || !st.shiftReg[0]) begin
                  next_st.busState = BUS_IDLE;
                  next_st.sdaOe = 1'b0;
                end
              end
            endcase
          end
        end
        BUS_ACK: begin
          if (sclFall) begin
            next_st.sdaOe = 1'b0;
            next_st.bitCount = 4'h0;
            unique case (st.phase)
              PHASE_WRITE_ADDR: begin
                next_st.busState = BUS_RECEIVE;
                next_st.phase = PHASE_REG_ADDR;
              end
              PHASE_REG_ADDR: begin
                next_st.busState = BUS_RECEIVE;
                next_st.phase = PHASE_DATA;
              end
              PHASE_DATA: begin
                next_st.busState = BUS_WAIT_STOP;
                next_st.phase = PHASE_WRITE_ADDR;
                next_st.writePending = 1'b1;
              end
              PHASE_READ_ADDR: begin
                next_st.busState = BUS_TRANSMIT;
                next_st.phase = PHASE_WRITE_ADDR;
                next_st.shiftReg = readByte;
                next_st.sdaOe = ~readByte[7];
                next_st.bitCount = 4'h1;
              end
            endcase
          end
        end
        BUS_TRANSMIT: begin
          if (sclFall) begin
            if (st.bitCount == BYTE_BITS) begin
              next_st.sdaOe = 1'b0;
              next_st.busState = BUS_TRANSMIT_ACK;
            end else begin
              next_st.shiftReg = {st.shiftReg[6:0], 1'b0};
              next_st.sdaOe = ~st.shiftReg[6];
              next_st.bitCount = st.bitCount + 4'h1;
            end
          end
        end
        BUS_TRANSMIT_ACK: begin
          if (sclRise) begin
            next_st.busState = BUS_WAIT_STOP;
          end
        end
        BUS_WAIT_STOP: begin
          // A further byte where a stop belongs breaks the frame; the stop's
          // own clock rise must not, so only a falling clock counts.
          if (sclFall) begin
            next_st.busState = BUS_IDLE;
            next_st.writePending = 1'b0;
          end
        end
      endcase
    end

    // The sense pin takes over from the setup bit only while dynamic
    // switching is on.
    next_st.selfPowered = st.setup.setupSecond[SECOND_DYNAMIC_POWER_BIT] ?
                          pinLevel[PIN_SENSE] :
                          st.setup.setupFirst[SETUP_POWER_SOURCE_BIT];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= HSC_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign smbDataOut = st.sdaOut;
  assign smbDataOe = st.sdaOe;
  assign usbAttach = st.usbAttach;
  assign smbInterfaceOff = st.usbAttach;
  assign configLock = st.configLock;
  assign selfPowered = st.selfPowered;
  assign dynamicPowerEnable = st.setup.setupSecond[SECOND_DYNAMIC_POWER_BIT];
  assign highSpeedOff = st.setup.setupFirst[SETUP_HIGH_SPEED_OFF_BIT];
  assign endOfPacketSuppress = st.setup.setupFirst[SETUP_EOP_SUPPRESS_BIT];
  assign overcurrentSenseMode =
    st.setup.setupFirst[SETUP_OC_MODE_MSB:SETUP_OC_MODE_LSB];
  assign vendorCode = st.setup.vendorCode;
  assign productCode = st.setup.productCode;
  assign releaseCode = st.setup.releaseCode;

endmodule

// ### rtl/hsc_pin_filter.sv
/*
  Three-stage synchroniser and agreement filter for the serial clock,
  serial data and local power sense pins.
  Assumes the pins are asynchronous to clock and idle high on the bus lanes.
*/
`timescale 1ns/1ps

module hsc_pin_filter
  import hsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] pinRaw,
  output logic [2:0] pinLevel
);

  hsc_filter_t st;
  hsc_filter_t next_st;

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  // The first stage feeds only the second; a level moves only when the
  // second and third stages agree, which hides a single metastable sample.
  always_comb begin
    next_st = st;
    next_st.stage1 = pinRaw;
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
    next_st.level = (st.stage2 & st.stage3) | (st.level & (st.stage2 | st.stage3));
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '{PIN_RESET_LEVEL, PIN_RESET_LEVEL, PIN_RESET_LEVEL, PIN_RESET_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign pinLevel = st.level;

endmodule

// ### rtl/hsc_pkg.sv
/*
  Shared constants and types of the hub configuration register bank:
  register offsets, field positions, reset values, the serial slave's
  states and the packed state records of both design modules.
  Assumes nothing of its surroundings; it is imported whole by each module.
*/
package hsc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_HUB_COMMAND = 8'h00;
  localparam logic [7:0] REG_VENDOR_CODE_LOW = 8'h01;
  localparam logic [7:0] REG_VENDOR_CODE_HIGH = 8'h02;
  localparam logic [7:0] REG_PRODUCT_CODE_LOW = 8'h03;
  localparam logic [7:0] REG_PRODUCT_CODE_HIGH = 8'h04;
  localparam logic [7:0] REG_RELEASE_CODE_LOW = 8'h05;
  localparam logic [7:0] REG_RELEASE_CODE_HIGH = 8'h06;
  localparam logic [7:0] REG_HUB_SETUP_FIRST = 8'h07;
  localparam logic [7:0] REG_HUB_SETUP_SECOND = 8'h08;
  localparam logic [7:0] LOCK_RANGE_FIRST = 8'h01;
  localparam logic [7:0] LOCK_RANGE_LAST = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int CMD_SOFT_RESET_BIT = 2;
  localparam int CMD_CONFIG_LOCK_BIT = 1;
  localparam int CMD_USB_ATTACH_BIT = 0;
  localparam int SETUP_POWER_SOURCE_BIT = 7;
  localparam int SETUP_HIGH_SPEED_OFF_BIT = 5;
  localparam int SETUP_EOP_SUPPRESS_BIT = 3;
  localparam int SETUP_OC_MODE_MSB = 2;
  localparam int SETUP_OC_MODE_LSB = 1;
  localparam int SECOND_DYNAMIC_POWER_BIT = 7;
  localparam logic [7:0] SETUP_FIRST_MASK = 8'hae;
  localparam logic [7:0] SECOND_MASK = 8'hb8;

  // ----------------------------------------------------------------------
  // Pin filter lanes and bus framing
  // ----------------------------------------------------------------------
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SENSE = 2;
  localparam logic [2:0] PIN_RESET_LEVEL = 3'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    BUS_IDLE = 6'b00_0001,
    BUS_RECEIVE = 6'b00_0010,
    BUS_ACK = 6'b00_0100,
    BUS_TRANSMIT = 6'b00_1000,
    BUS_TRANSMIT_ACK = 6'b01_0000,
    BUS_WAIT_STOP = 6'b10_0000
  } hsc_bus_state_t;

  typedef enum logic [3:0] {
    PHASE_WRITE_ADDR = 4'b0001,
    PHASE_REG_ADDR = 4'b0010,
    PHASE_DATA = 4'b0100,
    PHASE_READ_ADDR = 4'b1000
  } hsc_phase_t;

  typedef struct packed {
    logic [15:0] vendorCode;
    logic [15:0] productCode;
    logic [15:0] releaseCode;
    logic [7:0] setupFirst;
    logic [7:0] setupSecond;
  } hsc_setup_t;

  typedef struct packed {
    hsc_bus_state_t busState;
    hsc_phase_t phase;
    logic [3:0] bitCount;
    logic [7:0] shiftReg;
    logic [7:0] regAddr;
    logic [7:0] dataByte;
    logic writePending;
    logic softReset;
    logic configLock;
    logic usbAttach;
    logic sclLast;
    logic sdaLast;
    logic sdaOe;
    logic sdaOut;
    logic selfPowered;
    hsc_setup_t setup;
  } hsc_state_t;

  localparam hsc_state_t HSC_STATE_RESET = '{
    busState: BUS_IDLE,
    phase: PHASE_WRITE_ADDR,
    bitCount: 4'h0,
    shiftReg: 8'h00,
    regAddr: 8'h00,
    dataByte: 8'h00,
    writePending: 1'b0,
    softReset: 1'b0,
    configLock: 1'b0,
    usbAttach: 1'b0,
    sclLast: 1'b1,
    sdaLast: 1'b1,
    sdaOe: 1'b0,
    sdaOut: 1'b0,
    selfPowered: 1'b0,
    setup: '0
  };

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] stage3;
    logic [2:0] level;
  } hsc_filter_t;

endpackage

// ### test/hsc_config_regs_monitor.sv
/*
  Checker of the hub configuration register bank, bound to its top module.
  Assumes one clock domain with an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module hsc_config_regs_monitor
  import hsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic smbClockPin,
  input wire logic smbDataIn,
  input wire logic smbDataOe,
  input wire logic localPowerSensePin,
  input wire logic usbAttach,
  input wire logic smbInterfaceOff,
  input wire logic configLock,
  input wire logic selfPowered,
  input wire logic dynamicPowerEnable,
  input wire logic highSpeedOff,
  input wire logic endOfPacketSuppress,
  input wire logic [1:0] overcurrentSenseMode,
  input wire logic [15:0] vendorCode,
  input wire logic [15:0] productCode,
  input wire logic [15:0] releaseCode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence s_bus_idle;
    smbClockPin && smbDataIn;
  endsequence
  sequence s_sense_high;
    (dynamicPowerEnable && localPowerSensePin) [*8];
  endsequence
  sequence s_sense_low;
    (dynamicPowerEnable && !localPowerSensePin) [*8];
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_attach_off_same: assert property (
    usbAttach == smbInterfaceOff) else $error("Attach and slave shutdown differ.");
  a_attach_at_stop: assert property (
    $rose(usbAttach) |-> s_bus_idle) else $error("Attach took effect inside a transfer.");
  a_silent_after_attach: assert property (
    smbInterfaceOff |-> !smbDataOe) else $error("Slave drives data after attach.");
  a_attach_sticky: assert property (
    !$fell(usbAttach)) else $error("Attach cleared without pin reset.");
  a_lock_sticky: assert property (
    configLock |=> configLock) else $error("Lock cleared without pin reset.");
  a_locked_codes_hold: assert property (
    configLock |=> ($stable(vendorCode) || vendorCode == 16'h0000)
      && ($stable(productCode) || productCode == 16'h0000)
      && ($stable(releaseCode) || releaseCode == 16'h0000))
    else $error("Locked code changed.");
  a_locked_setup_hold: assert property (
    configLock |=> $stable({highSpeedOff, endOfPacketSuppress, overcurrentSenseMode})
      || {highSpeedOff, endOfPacketSuppress, overcurrentSenseMode} == 4'h0)
    else $error("Locked setup changed.");
  a_sense_high_self: assert property (
    s_sense_high |-> selfPowered) else $error("Sense high but bus powered.");
  a_sense_low_bus: assert property (
    s_sense_low |-> !selfPowered) else $error("Sense low but self powered.");
  a_codes_when_idle: assert property (
    $changed({vendorCode, productCode, releaseCode}) |-> s_bus_idle)
    else $error("Code changed during a transfer.");
endmodule

bind hsc_config_regs hsc_config_regs_monitor i_monitor (
  .clock(clock), .reset(reset), .smbClockPin(smbClockPin), .smbDataIn(smbDataIn),
  .smbDataOe(smbDataOe), .localPowerSensePin(localPowerSensePin),
  .usbAttach(usbAttach), .smbInterfaceOff(smbInterfaceOff), .configLock(configLock),
  .selfPowered(selfPowered), .dynamicPowerEnable(dynamicPowerEnable),
  .highSpeedOff(highSpeedOff), .endOfPacketSuppress(endOfPacketSuppress),
  .overcurrentSenseMode(overcurrentSenseMode), .vendorCode(vendorCode),
  .productCode(productCode), .releaseCode(releaseCode)
);

// ### test/hsc_smbus_host.sv
/*
  Behavioural two-wire bus host that loads and reads hub configuration.
  Assumes the data line has a pull-up and the slave pulls it through dataOe.
*/
`timescale 1ns/1ps

module hsc_smbus_host
  import hsc_pkg::*;
(
  input wire logic clock,
  input wire logic dataOe,
  output logic sclPin,
  output logic sdaWire
);
  logic sdaRelease;

  // Pull-up: the line is low only while some party pulls it.
  assign sdaWire = sdaRelease & ~dataOe;

  initial begin
    sclPin = 1'b1;
    sdaRelease = 1'b1;
  end

  // Eight clocks per phase leaves margin over the slave's pin filter.
  task automatic half();
    repeat (8) @(negedge clock);
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sdaRelease = (i < 0) ? 1'b1 : b[i];
      half();
      sclPin = 1'b1;
      half();
      ack = ~sdaWire;
      sclPin = 1'b0;
      half();
    end
  endtask

  task automatic recvByte(output logic [7:0] b);
    sdaRelease = 1'b1;
    for (int i = 7; i >= -1; i--) begin
      half();
      sclPin = 1'b1;
      half();
      if (i >= 0) b[i] = sdaWire;
      sclPin = 1'b0;
      half();
    end
  endtask

  task automatic startBit(input logic again);
    sdaRelease = 1'b1;
    half();
    sclPin = 1'b1;
    half();
    sdaRelease = 1'b0;
    half();
    sclPin = 1'b0;
    if (again) half();
  endtask

  task automatic stopBit();
    sdaRelease = 1'b0;
    half();
    sclPin = 1'b1;
    half();
    sdaRelease = 1'b1;
    half();
  endtask

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2;
    startBit(1'b0);
    sendByte({dev, 1'b0}, a0);
    sendByte(a, a1);
    sendByte(d, a2);
    stopBit();
    ok = a0 & a1 & a2;
  endtask

  task automatic readReg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
    logic a0, a1, a2;
    startBit(1'b0);
    sendByte({dev, 1'b0}, a0);
    sendByte(a, a1);
    startBit(1'b1);
    sendByte({dev, 1'b1}, a2);
    recvByte(d);
    stopBit();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ### test/test_hsc_config_regs.sv
/*
  Self-checking bench of the hub configuration register bank: register
  writes and reads through the bus host model, compared with expectations.
  Assumes the host model and the bound checker from the same folder.
*/
`timescale 1ns/1ps

module test_hsc_config_regs
  import hsc_pkg::*;
;
  localparam logic [6:0] SLAVE = 7'h2c;
  logic clock, reset, sense, sclPin, sdaWire, dataOe, usbAttach, slaveOff;
  logic configLock, selfPowered, dynamicPowerEnable, highSpeedOff, endOfPacketSuppress;
  logic [1:0] ocMode;
  logic [15:0] vendorCode, productCode, releaseCode;
  logic ok, dataOut;
  logic [7:0] rd, v;
  int fails, checksDone;

  hsc_config_regs i_dut (
    .clock(clock), .reset(reset), .slaveAddress(SLAVE), .smbClockPin(sclPin),
    .smbDataIn(sdaWire), .smbDataOut(dataOut), .smbDataOe(dataOe),
    .localPowerSensePin(sense), .usbAttach(usbAttach), .smbInterfaceOff(slaveOff),
    .configLock(configLock), .selfPowered(selfPowered),
    .dynamicPowerEnable(dynamicPowerEnable), .highSpeedOff(highSpeedOff),
    .endOfPacketSuppress(endOfPacketSuppress), .overcurrentSenseMode(ocMode),
    .vendorCode(vendorCode), .productCode(productCode), .releaseCode(releaseCode)
  );
  hsc_smbus_host i_host (.clock(clock), .dataOe(dataOe), .sclPin(sclPin), .sdaWire(sdaWire));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Access and reporting tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic expAck);
    i_host.writeReg(SLAVE, a, d, ok);
    check(16'(ok), 16'(expAck));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_host.readReg(SLAVE, a, rd, ok);
    check(16'({ok, rd}), 16'({1'b1, exp}));
  endtask

  task automatic wrap_up();
    if (fails == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung transfer cannot keep the run going past this bound.
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    sense = 1'b0;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    repeat (8) @(negedge clock);
    for (int a = 0; a < 8; a++) rdc(8'(a), 8'h00);
    check(16'(dataOut), 16'h0000);
    for (int a = 1; a < 7; a++) wr(8'(a), 8'(a * 17), 1'b1);
    check(vendorCode, 16'h2211);
    check(productCode, 16'h4433);
    check(releaseCode, 16'h6655);
    rdc(REG_PRODUCT_CODE_LOW, 8'h33);
    for (int m = 0; m < 4; m++) begin
      // Power source follows the sensing mode so no-sensing runs bus powered.
      v = {~m[1], 1'b1, m[0], 1'b1, ~m[0], m[1:0], 1'b1};
      wr(REG_HUB_SETUP_FIRST, v, 1'b1);
      check(16'({selfPowered, highSpeedOff, endOfPacketSuppress, ocMode}),
            16'({~m[1], m[0], ~m[0], m[1:0]}));
      rdc(REG_HUB_SETUP_FIRST, v & 8'hae);
    end
    wr(REG_HUB_SETUP_FIRST, 8'h80, 1'b1);
    wr(REG_HUB_SETUP_SECOND, 8'hb8, 1'b1);
    check(16'({dynamicPowerEnable, selfPowered}), 16'h0002);
    sense = 1'b1;
    repeat (8) @(negedge clock);
    check(16'(selfPowered), 16'h0001);
    sense = 1'b0;
    wr(REG_HUB_SETUP_SECOND, 8'h00, 1'b1);
    check(16'({dynamicPowerEnable, selfPowered}), 16'h0001);
    wr(8'h09, 8'hff, 1'b1);
    rdc(8'h09, 8'h00);
    for (int k = 0; k < 2; k++) begin
      i_host.writeReg(k ? 7'h00 : 7'h2d, REG_VENDOR_CODE_LOW, 8'hee, ok);
      check(16'(ok), 16'h0000);
    end
    check(vendorCode, 16'h2211);
    wr(REG_HUB_COMMAND, 8'h04, 1'b1);
    check(vendorCode | productCode | releaseCode, 16'h0000);
    check(16'({selfPowered, highSpeedOff, endOfPacketSuppress, ocMode}), 16'h0000);
    rdc(REG_HUB_COMMAND, 8'h00);
    wr(REG_VENDOR_CODE_LOW, 8'h5a, 1'b1);
    wr(REG_HUB_COMMAND, 8'h02, 1'b1);
    wr(REG_VENDOR_CODE_LOW, 8'ha5, 1'b1);
    wr(REG_HUB_SETUP_FIRST, 8'h2a, 1'b1);
    check(vendorCode, 16'h005a);
    check(16'({configLock, highSpeedOff}), 16'h0002);
    rdc(REG_VENDOR_CODE_LOW, 8'h5a);
    wr(REG_HUB_COMMAND, 8'h00, 1'b1);
    rdc(REG_HUB_COMMAND, 8'h02);
    wr(REG_HUB_COMMAND, 8'h03, 1'b1);
    check(16'({usbAttach, slaveOff}), 16'h0003);
    i_host.readReg(SLAVE, REG_HUB_COMMAND, rd, ok);
    check(16'(ok), 16'h0000);
    wr(REG_HUB_COMMAND, 8'h00, 1'b0);
    check(16'({usbAttach, configLock}), 16'h0003);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    repeat (8) @(negedge clock);
    check(16'({usbAttach, configLock}) | vendorCode, 16'h0000);
    rdc(REG_HUB_COMMAND, 8'h00);
    wrap_up();
  end
endmodule
